// ===== hw/ttr_cfg.svh
// ttr_cfg.svh: register map, field positions, reset values and window counts
// for the teletext request window timing block.
// assumes: included by bare name from each module file of the block.
`ifndef TTR_CFG_SVH
`define TTR_CFG_SVH

// ==========================================================================
// register subaddresses (five-bit register port)
`define TTR_ADDR_EDGE 5'h19
`define TTR_ADDR_ENABLE_BASE 5'h1a
`define TTR_ADDR_BITS_LOW 5'h1e
`define TTR_ADDR_STATUS 5'h1f
`define TTR_ENABLE_REGS 4

// ==========================================================================
// edge control fields
`define TTR_RISE_MSB 7
`define TTR_RISE_LSB 4
`define TTR_FALL_MSB 3
`define TTR_FALL_LSB 0

// ==========================================================================
// reset values and constants
`define TTR_REG_RESET 8'h00
`define TTR_NIBBLE_ZERO 4'h0
`define TTR_BYTE_ZERO 8'h00
`define TTR_CNT_ZERO 11'h000
`define TTR_CNT_ONE 11'h001
`define TTR_CNT_MAX 11'h7ff
`define TTR_BITS_ZERO 9'h000
`define TTR_BITS_ONE 9'h001

// ==========================================================================
// request window: nominal start after line start and default width in clocks
`define TTR_BASE_START 11'h040
`define TTR_DEFAULT_BITS 11'h168

// ==========================================================================
// lines that carry teletext enables
`define TTR_FIRST_LINE 10'h007
`define TTR_LINE_COUNT 10'h010

`endif

// ===== hw/ttr_pkg.sv
// ttr_pkg.sv: types shared by the teletext request window timing block.
// assumes: compiled before the modules that import it.
package ttr_pkg;

    typedef enum logic [1:0] {
        TTR_IDLE = 2'b00,
        TTR_WAIT_RISE = 2'b01,
        TTR_ACTIVE = 2'b10
    } ttr_state_type;

endpackage

// ===== hw/ttr_strobe_gen.sv
// ttr_strobe_gen.sv: per-line sequencer that raises and drops the teletext
// request strobe at the given cycle positions after a line start.
// assumes: line_start is a one-cycle pulse on clk; fall_pos above rise_pos.
`timescale 1ns/100ps
`include "ttr_cfg.svh"

module ttr_strobe_gen
    import ttr_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic line_start,
    input wire logic line_enabled,
    input wire logic [10:0] rise_pos,
    input wire logic [10:0] fall_pos,
    output logic strobe_q,
    output ttr_state_type state_q
);

    ttr_state_type state_d;
    logic [10:0] cnt_q;
    logic [10:0] cnt_d;
    logic [10:0] rise_q;
    logic [10:0] rise_d;
    logic [10:0] fall_q;
    logic [10:0] fall_d;
    logic strobe_d;

    // ======================================================================
    // sequencer
    // positions are frozen at line start so a register write mid-line
    // cannot cut a window short or make it run past its end
    always_comb begin
        state_d = state_q;
        strobe_d = strobe_q;
        rise_d = rise_q;
        fall_d = fall_q;
        cnt_d = (cnt_q == `TTR_CNT_MAX) ? cnt_q : cnt_q + `TTR_CNT_ONE;
        if (line_start) begin
            cnt_d = `TTR_CNT_ZERO;
            rise_d = rise_pos;
            fall_d = fall_pos;
            strobe_d = 1'b0;
            state_d = line_enabled ? TTR_WAIT_RISE : TTR_IDLE;
        end else begin
            case (state_q)
                TTR_IDLE: begin
                    strobe_d = 1'b0;
                end
                TTR_WAIT_RISE: begin
                    if (cnt_q == rise_q) begin
                        strobe_d = 1'b1;
                        state_d = TTR_ACTIVE;
                    end
                end
                TTR_ACTIVE: begin
                    if (cnt_q == fall_q) begin
                        strobe_d = 1'b0;
                        state_d = TTR_IDLE;
                    end
                end
                default: begin
                    strobe_d = 1'b0;
                    state_d = TTR_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= TTR_IDLE;
            strobe_q <= 1'b0;
            cnt_q <= `TTR_CNT_ZERO;
            rise_q <= `TTR_CNT_ZERO;
            fall_q <= `TTR_CNT_ZERO;
        end else begin
            state_q <= state_d;
            strobe_q <= strobe_d;
            cnt_q <= cnt_d;
            rise_q <= rise_d;
            fall_q <= fall_d;
        end
    end

endmodule

// ===== hw/ttr_top.sv
// ttr_top.sv: teletext request window timing, register file and line gating.
// assumes: video timing on clk supplies line_start, field_odd and line_number;
// the teletext source samples teletext_request_strobe on the same clock.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/100ps
`include "ttr_cfg.svh"

module ttr_top
    import ttr_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [4:0] reg_addr,
    input wire logic [7:0] reg_wr_data,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rd_data,
    input wire logic line_start,
    input wire logic field_odd,
    input wire logic [9:0] line_number,
    output logic teletext_request_strobe
);

    // ======================================================================
    // decoding helpers
    function automatic logic ttr_line_enabled(
        input logic [9:0] line,
        input logic [15:0] enables
    );
        logic [9:0] idx;
        idx = line - `TTR_FIRST_LINE;
        ttr_line_enabled = 1'b0;
        if (line >= `TTR_FIRST_LINE && idx < `TTR_LINE_COUNT) begin
            ttr_line_enabled = enables[idx[3:0]];
        end
    endfunction

    function automatic logic ttr_hit(
        input logic [4:0] addr,
        input logic [4:0] target
    );
        ttr_hit = (addr == target);
    endfunction

    // ======================================================================
    // edge control register
    // offsets are frozen by the sequencer at line start, so a write lands on the next line
    logic [7:0] edge_ctrl_q;
    logic [7:0] edge_ctrl_d;

    always_comb begin
        edge_ctrl_d = edge_ctrl_q;
        if (reg_wr && ttr_hit(reg_addr, `TTR_ADDR_EDGE)) begin
            edge_ctrl_d = reg_wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            edge_ctrl_q <= `TTR_REG_RESET;
        end else begin
            edge_ctrl_q <= edge_ctrl_d;
        end
    end

    // ======================================================================
    // line enable registers: odd low, odd high, even low, even high
    // bit i of each 16-bit pair enables line 7 + i; lines outside never request
    logic [7:0] line_en_q [`TTR_ENABLE_REGS];
    logic [7:0] line_en_d [`TTR_ENABLE_REGS];

    genvar gi;
    generate
        for (gi = 0; gi < `TTR_ENABLE_REGS; gi = gi + 1) begin : g_line_en
            localparam logic [4:0] ADDR = `TTR_ADDR_ENABLE_BASE + 5'(gi);
            always_comb begin
                line_en_d[gi] = line_en_q[gi];
                if (reg_wr && ttr_hit(reg_addr, ADDR)) begin
                    line_en_d[gi] = reg_wr_data;
                end
            end
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    line_en_q[gi] <= `TTR_REG_RESET;
                end else begin
                    line_en_q[gi] <= line_en_d[gi];
                end
            end
        end
    endgenerate

    logic [15:0] odd_field_line_enables;
    logic [15:0] even_field_line_enables;
    assign odd_field_line_enables = {line_en_q[1], line_en_q[0]};
    assign even_field_line_enables = {line_en_q[3], line_en_q[2]};

    // ======================================================================
    // window positions in clocks after line start
    logic [3:0] request_rise_offset;
    logic [3:0] request_fall_offset;
    logic [10:0] rise_pos;
    logic [10:0] fall_pos;
    logic line_enabled;

    assign request_rise_offset = edge_ctrl_q[`TTR_RISE_MSB:`TTR_RISE_LSB];
    assign request_fall_offset = edge_ctrl_q[`TTR_FALL_MSB:`TTR_FALL_LSB];

    always_comb begin
        rise_pos = `TTR_BASE_START + {7'h00, request_rise_offset};
        if (request_fall_offset == `TTR_NIBBLE_ZERO) begin
            // falling edge tracks the rising edge, width stays at default
            fall_pos = rise_pos + `TTR_DEFAULT_BITS;
        end else begin
            // fixed end pulled in by the falling offset; window shrinks
            fall_pos = `TTR_BASE_START + `TTR_DEFAULT_BITS
                - {7'h00, request_fall_offset};
        end
    end

    always_comb begin
        if (field_odd) begin
            line_enabled = ttr_line_enabled(line_number, odd_field_line_enables);
        end else begin
            line_enabled = ttr_line_enabled(line_number, even_field_line_enables);
        end
    end

    // ======================================================================
    // strobe sequencer
    ttr_state_type gen_state;

    ttr_strobe_gen u_gen (
        .clk(clk),
        .sys_rst(sys_rst),
        .line_start(line_start),
        .line_enabled(line_enabled),
        .rise_pos(rise_pos),
        .fall_pos(fall_pos),
        .strobe_q(teletext_request_strobe),
        .state_q(gen_state)
    );

    // ======================================================================
    // requested bit count: lets software see the window width it programmed
    // nine bits cover the widest window; an aborted line reports the part it ran
    logic [8:0] bit_cnt_q;
    logic [8:0] bit_cnt_d;
    logic [8:0] last_bits_q;
    logic [8:0] last_bits_d;
    logic line_gated_q;
    logic line_gated_d;

    always_comb begin
        bit_cnt_d = bit_cnt_q;
        last_bits_d = last_bits_q;
        line_gated_d = line_gated_q;
        if (line_start) begin
            last_bits_d = bit_cnt_q;
            bit_cnt_d = `TTR_BITS_ZERO;
            line_gated_d = line_enabled;
        end else if (teletext_request_strobe) begin
            bit_cnt_d = bit_cnt_q + `TTR_BITS_ONE;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bit_cnt_q <= `TTR_BITS_ZERO;
            last_bits_q <= `TTR_BITS_ZERO;
            line_gated_q <= 1'b0;
        end else begin
            bit_cnt_q <= bit_cnt_d;
            last_bits_q <= last_bits_d;
            line_gated_q <= line_gated_d;
        end
    end

    // ======================================================================
    // read port: data one cycle after the read strobe, zero otherwise
    // count and status are read-only: writes there fall through like unmapped ones
    logic [7:0] rd_data_d;
    logic [7:0] rd_data_q;

    always_comb begin
        rd_data_d = `TTR_BYTE_ZERO;
        if (reg_rd) begin
            if (ttr_hit(reg_addr, `TTR_ADDR_EDGE)) begin
                rd_data_d = edge_ctrl_q;
            end else if (ttr_hit(reg_addr, `TTR_ADDR_ENABLE_BASE)) begin
                rd_data_d = line_en_q[0];
            end else if (ttr_hit(reg_addr, `TTR_ADDR_ENABLE_BASE + 5'h01)) begin
                rd_data_d = line_en_q[1];
            end else if (ttr_hit(reg_addr, `TTR_ADDR_ENABLE_BASE + 5'h02)) begin
                rd_data_d = line_en_q[2];
            end else if (ttr_hit(reg_addr, `TTR_ADDR_ENABLE_BASE + 5'h03)) begin
                rd_data_d = line_en_q[3];
            end else if (ttr_hit(reg_addr, `TTR_ADDR_BITS_LOW)) begin
                rd_data_d = last_bits_q[7:0];
            end else if (ttr_hit(reg_addr, `TTR_ADDR_STATUS)) begin
                rd_data_d = {3'h0, line_gated_q, gen_state, teletext_request_strobe,
                    last_bits_q[8]};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_data_q <= `TTR_BYTE_ZERO;
        end else begin
            rd_data_q <= rd_data_d;
        end
    end

    assign reg_rd_data = rd_data_q;

endmodule

// ===== verif/ttr_top_checker.sv
// ttr_top_checker.sv: port-level checks of ttr_top.
// assumes: bound to ttr_top; shadows follow the register write strobe.
`timescale 1ns/100ps
module ttr_top_checker (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [4:0] reg_addr,
    input wire logic [7:0] reg_wr_data,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rd_data,
    input wire logic line_start,
    input wire logic field_odd,
    input wire logic [9:0] line_number,
    input wire logic teletext_request_strobe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic [7:0] edge_q;
    logic [7:0] en_q [4];
    logic [3:0] rise_q, fall_q;
    logic gate_q;
    logic [10:0] cnt_q, rise_e, fall_e;
    logic [15:0] en_sel;
    logic [9:0] idx;
    logic [4:0] ofs;
    assign idx = line_number - 10'h007;
    assign ofs = reg_addr - 5'h1a;
    assign en_sel = field_odd ? {en_q[1], en_q[0]} : {en_q[3], en_q[2]};
    // expected strobe edges, as cycles counted from the line start
    assign rise_e = 11'h042 + 11'(rise_q);
    assign fall_e = (fall_q == 4'h0) ? rise_e + 11'h168 : 11'h1aa - 11'(fall_q);
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            edge_q <= 8'h00;
            en_q <= '{default: 8'h00};
            cnt_q <= 11'h000;
            gate_q <= 1'b0;
            rise_q <= 4'h0;
            fall_q <= 4'h0;
        end else begin
            if (reg_wr && reg_addr == 5'h19) begin
                edge_q <= reg_wr_data;
            end
            if (reg_wr && reg_addr >= 5'h1a && reg_addr <= 5'h1d) begin
                en_q[ofs[1:0]] <= reg_wr_data;
            end
            if (line_start) begin
                cnt_q <= 11'h001;
                rise_q <= edge_q[7:4];
                fall_q <= edge_q[3:0];
                gate_q <= line_number >= 10'h007 && line_number <= 10'h016 && en_sel[idx[3:0]];
            end else if (cnt_q != 11'h7ff) begin
                cnt_q <= cnt_q + 11'h001;
            end
        end
    end
    rd_idle_a: assert property (!$past(reg_rd) |-> reg_rd_data == 8'h00)
        else $error("read data not idle");
    rd_edge_a: assert property (reg_rd && reg_addr == 5'h19 |=> reg_rd_data == edge_q)
        else $error("edge control read wrong");
    rst_quiet_a: assert property ($fell(sys_rst) |-> !teletext_request_strobe)
        else $error("strobe high after reset");
    rise_pos_a: assert property ($rose(teletext_request_strobe) |-> cnt_q == rise_e)
        else $error("strobe rose at wrong cycle");
    gated_line_a: assert property ($rose(teletext_request_strobe) |-> gate_q)
        else $error("strobe on disabled line");
    fall_pos_a: assert property ($fell(teletext_request_strobe) |->
        cnt_q == fall_e || cnt_q == 11'h001) else $error("strobe fell at wrong cycle");
    window_a: assert property (teletext_request_strobe |->
        cnt_q >= rise_e && cnt_q < fall_e) else $error("strobe outside window");
    track_width_a: assert property ($fell(teletext_request_strobe) && fall_q == 4'h0 &&
        cnt_q != 11'h001 |-> cnt_q - rise_e == 11'h168) else $error("width not held");
endmodule

bind ttr_top ttr_top_checker chk (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data),
    .line_start(line_start), .field_odd(field_odd), .line_number(line_number),
    .teletext_request_strobe(teletext_request_strobe));

// ===== verif/ttr_source_model.sv
// ttr_source_model.sv: teletext source side; counts requested bits per line.
// assumes: request sampled on clk; a line begins with a one-cycle line_start.
`timescale 1ns/100ps
module ttr_source_model (
    input wire logic clk,
    input wire logic line_start,
    input wire logic request,
    output int rise_at,
    output int width
);
    int cnt = 0;
    always @(posedge clk) begin
        if (line_start) begin
            cnt <= 1;
            rise_at <= -1;
            width <= 0;
        end else begin
            cnt <= cnt + 1;
            // one requested bit per strobe-high cycle
            if (request) begin
                width <= width + 1;
                if (rise_at < 0) begin
                    rise_at <= cnt;
                end
            end
        end
    end
endmodule

// ===== verif/tb_teletext_request_window_timing.sv
// tb_teletext_request_window_timing.sv: register and line window tests of ttr_top.
// assumes: ttr_source_model watches the strobe; the checker is bound to ttr_top.
`timescale 1ns/100ps
module tb_teletext_request_window_timing;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [4:0] reg_addr = 5'h00;
    logic [7:0] reg_wr_data = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rd_data;
    logic line_start = 1'b0;
    logic field_odd = 1'b0;
    logic [9:0] line_number = 10'h000;
    logic strobe;
    logic s_after;
    int rise_at;
    int width;
    int errors = 0;
    int compares = 0;
    logic [7:0] d, d2;
    logic [15:0] exp_w;
    logic [7:0] edges [5] = '{8'h00, 8'hf0, 8'h0f, 8'h5a, 8'h01};
    // bit 11 enabled, bit 10 odd field, low bits line number
    logic [11:0] lines [6] = '{12'hc07, 12'h408, 12'h816, 12'h007, 12'h417, 12'h006};
    ttr_top uut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data), .line_start(line_start),
        .field_odd(field_odd), .line_number(line_number), .teletext_request_strobe(strobe));
    ttr_source_model src (.clk(clk), .line_start(line_start), .request(strobe),
        .rise_at(rise_at), .width(width));
    initial begin
        forever #2 clk = ~clk;
    end
    // ==========================================================================
    // tasks
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wr_data <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rd_data;
    endtask
    task automatic run_line(input logic odd, input logic [9:0] ln, input int n);
        @(posedge clk);
        line_start <= 1'b1;
        field_odd <= odd;
        line_number <= ln;
        @(posedge clk);
        line_start <= 1'b0;
        #1 s_after = strobe;
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ==========================================================================
    // tests
    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        for (int a = 'h19; a <= 'h1f; a++) begin
            rd(5'(a), d);
            check("reset value", 16'h0000, {8'h00, d});
        end
        wr(5'h05, 8'hff);
        rd(5'h05, d);
        check("unmapped read", 16'h0000, {8'h00, d});
        wr(5'h19, 8'ha5);
        rd(5'h19, d);
        check("edge control", 16'h00a5, {8'h00, d});
        wr(5'h1a, 8'h01);
        wr(5'h1d, 8'h80);
        rd(5'h1d, d);
        check("even enables", 16'h0080, {8'h00, d});
        $display("test registers done");
        // narrower windows when the falling offset grows; fixed width when it is zero
        foreach (edges[i]) begin
            wr(5'h19, edges[i]);
            run_line(1'b1, 10'h007, 440);
            exp_w = (edges[i][3:0] == 4'h0) ? 16'h0168 :
                16'h0168 - 16'(edges[i][3:0]) - 16'(edges[i][7:4]);
            check("rise cycle", 16'h0042 + 16'(edges[i][7:4]), 16'(rise_at));
            check("window width", exp_w, 16'(width));
            run_line(1'b0, 10'h01e, 8);
            rd(5'h1e, d);
            rd(5'h1f, d2);
            check("bit count", exp_w, {7'h00, d2[0], d});
        end
        $display("test edges done");
        wr(5'h19, 8'h00);
        foreach (lines[i]) begin
            run_line(lines[i][10], lines[i][9:0], 440);
            check("gated width", lines[i][11] ? 16'h0168 : 16'h0000, 16'(width));
        end
        $display("test gating done");
        run_line(1'b1, 10'h007, 100);
        check("strobe mid window", 16'h0001, {15'h0000, strobe});
        rd(5'h1f, d2);
        check("status mid window", 16'h001a, {8'h00, d2});
        run_line(1'b0, 10'h01e, 440);
        check("strobe after abort", 16'h0000, {15'h0000, s_after});
        $display("test abort done");
        conclude();
    end
    initial begin
        repeat (12000) @(posedge clk);
        errors++;
        conclude();
    end
endmodule
